// ===== rtl/motor_tuning_register_bank.sv
// Motor tuning register bank: halt control, tach/resistance and bemf/advance words.
// Assumes the serial register port is already decoded into word strobes on clk.
//
// Overview of operation
// - Addresses 0x37 to 0x5F do nothing
// - Addresses 0x61 to 0x8F do nothing
// - Halt bit is write-only, reads back zero
// - Halt 1 stops motor, 0 re-enables
// - Dither field selects none, 5, 10, 15 percent
// - Tach open-loop field gates tach pulses
// - Tach rate is electrical rate over n+1
// - Cycle adjust bit: full or half cycle
// - Resistance is mantissa shifted by shift count
// - Bemf constant is mantissa shifted by shift
// - Advance mode fixed or scaled by bemf ratio
// - Advance time is mantissa shifted by shift
// - Tach/resistance word resets to zero
// - Pointer 0x90 selects tach/resistance word
`timescale 1ns/1ps
`default_nettype none
module motor_tuning_register_bank (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// Decoded register port
	input  wire logic [7:0]                     reg_addr,
	input  wire logic [15:0]                    reg_wdata,
	input  wire logic                           reg_wr_en,
	input  wire logic                           reg_rd_en,
	output var  logic [15:0]                    reg_rdata,
	output var  logic                           reg_rd_valid,
	// Single-location non-volatile access
	input  wire logic [7:0]                     single_access_pointer,
	input  wire logic                           nv_load_en,
	input  wire logic [15:0]                    nv_load_data,
	output var  logic [15:0]                    nv_read_data,
	// Motor-side status
	input  wire logic                           elec_pulse,
	input  wire logic                           closed_loop,
	input  wire logic                           first_open_loop,
	input  wire logic [motor_tuning_pkg::RATIO_FRAC_BITS:0] bemf_ratio_q8,
	// Configuration outputs
	output var  logic                           motor_halt_bit,
	output var  motor_tuning_pkg::dither_select_t dither_select,
	output var  logic                           cycle_adjust_select,
	output var  logic [motor_tuning_pkg::PARAM_W-1:0] resistance_param,
	output var  logic [motor_tuning_pkg::PARAM_W-1:0] bemf_const_param,
	output var  logic                           advance_mode_select,
	output var  logic [motor_tuning_pkg::PARAM_W-1:0] advance_time_param,
	output var  logic                           tach_output
);
	import motor_tuning_pkg::*;

	localparam int PROD_W = PARAM_W + RATIO_FRAC_BITS + 1;

	typedef struct packed {
		logic                halt;
		logic [15:0]         tach_res_word;
		logic [15:0]         bemf_adv_word;
		logic [15:0]         rdata;
		logic                rd_valid;
		logic [15:0]         nv_rdata;
		logic [PARAM_W-1:0]  res_param;
		logic [PARAM_W-1:0]  bemf_param;
		logic [PARAM_W-1:0]  adv_param;
	} bank_state_t;

	bank_state_t state_reg;
	bank_state_t state_next;

	tach_cfg_if tach_cfg ();

	// -----------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------
	function automatic logic [PARAM_W-1:0] expand(input logic [3:0] mant,
	                                              input logic [2:0] shift);
		logic [PARAM_W-1:0] wide;
		wide = {{(PARAM_W-4){1'b0}}, mant};
		return wide << shift;
	endfunction

	function automatic logic [15:0] read_word(input logic [7:0] addr,
	                                          input logic [15:0] tr_word,
	                                          input logic [15:0] ba_word);
		logic [15:0] value;
		value = 16'h0000;
		case (addr)
			// Halt register reads all zero; the halt bit never shows
			MOTOR_HALT_REGISTER_ADDR: value = 16'h0000;
			TACH_RES_WORD_ADDR:       value = tr_word;
			BEMF_ADV_WORD_ADDR:       value = ba_word & BEMF_ADV_WRITE_MASK;
			// Unused ranges and everything else read zero
			default:                  value = 16'h0000;
		endcase
		return value;
	endfunction

	logic [3:0]        adv_mant;
	logic [2:0]        adv_shift;
	logic [PARAM_W-1:0] adv_base;
	logic [PROD_W-1:0] adv_scaled;

	// -----------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.rd_valid = 1'b0;

		// Register writes; unmapped indices fall through untouched
		if (reg_wr_en) begin
			case (reg_addr)
				MOTOR_HALT_REGISTER_ADDR:
					state_next.halt = reg_wdata[MOTOR_HALT_BIT_POS];
				TACH_RES_WORD_ADDR:
					state_next.tach_res_word = reg_wdata;
				BEMF_ADV_WORD_ADDR:
					state_next.bemf_adv_word = reg_wdata & BEMF_ADV_WRITE_MASK;
				default: ;
			endcase
		end else if (nv_load_en) begin
			// Non-volatile load lands on the word the pointer names
			case (single_access_pointer)
				TACH_RES_WORD_ADDR: state_next.tach_res_word = nv_load_data;
				BEMF_ADV_WORD_ADDR:
					state_next.bemf_adv_word = nv_load_data & BEMF_ADV_WRITE_MASK;
				default: ;
			endcase
		end

		if (reg_rd_en) begin
			state_next.rdata    = read_word(reg_addr, state_reg.tach_res_word,
			                                state_reg.bemf_adv_word);
			state_next.rd_valid = 1'b1;
		end
		state_next.nv_rdata = read_word(single_access_pointer, state_reg.tach_res_word,
		                                state_reg.bemf_adv_word);

		// Derived motor parameters, one cycle behind the words
		state_next.res_param = expand(
			state_reg.tach_res_word[RES_MANTISSA_LSB +: 4],
			state_reg.tach_res_word[RES_SHIFT_LSB +: 3]);
		state_next.bemf_param = expand(
			state_reg.bemf_adv_word[BEMF_MANTISSA_LSB +: 4],
			state_reg.bemf_adv_word[BEMF_SHIFT_LSB +: 3]);

		adv_mant   = state_reg.bemf_adv_word[ADV_MANTISSA_LSB +: 4];
		adv_shift  = state_reg.bemf_adv_word[ADV_SHIFT_LSB +: 3];
		adv_base   = expand(adv_mant, adv_shift);
		adv_scaled = PROD_W'(adv_base) * PROD_W'(bemf_ratio_q8);
		// Scaled mode saturates rather than wrap when the scaled result overflows 11 bits
		if (!state_reg.bemf_adv_word[ADV_MODE_POS]) begin
			state_next.adv_param = adv_base;
		end else if (|adv_scaled[PROD_W-1:PARAM_W+RATIO_FRAC_BITS]) begin
			state_next.adv_param = '1;
		end else begin
			state_next.adv_param = adv_scaled[RATIO_FRAC_BITS +: PARAM_W];
		end
	end

	// -----------------------------------------------------------
	// State register
	// -----------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg               <= '0;
			state_reg.halt          <= MOTOR_HALT_RESET;
			state_reg.tach_res_word <= TACH_RES_WORD_RESET;
			state_reg.bemf_adv_word <= BEMF_ADV_WORD_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// -----------------------------------------------------------
	// Outputs and tach divider
	// -----------------------------------------------------------
	assign tach_cfg.openloop_select =
		tach_openloop_select_t'(state_reg.tach_res_word[TACH_OL_SELECT_LSB +: 2]);
	assign tach_cfg.divider = state_reg.tach_res_word[TACH_DIVIDER_LSB +: 4];

	tach_divider u_tach (
		.clk             (clk),
		.rst_n           (rst_n),
		.cfg             (tach_cfg),
		.elec_pulse      (elec_pulse),
		.closed_loop     (closed_loop),
		.first_open_loop (first_open_loop),
		.tach_output     (tach_output)
	);

	assign reg_rdata           = state_reg.rdata;
	assign reg_rd_valid        = state_reg.rd_valid;
	assign nv_read_data        = state_reg.nv_rdata;
	assign motor_halt_bit      = state_reg.halt;
	assign dither_select       =
		dither_select_t'(state_reg.tach_res_word[DITHER_SELECT_LSB +: 2]);
	assign cycle_adjust_select = state_reg.tach_res_word[CYCLE_ADJUST_POS];
	assign advance_mode_select = state_reg.bemf_adv_word[ADV_MODE_POS];
	assign resistance_param    = state_reg.res_param;
	assign bemf_const_param    = state_reg.bemf_param;
	assign advance_time_param  = state_reg.adv_param;
endmodule
`default_nettype wire

// ===== rtl/motor_tuning_pkg.sv
// Package of constants for the motor tuning register bank.
// Assumes 16-bit register words addressed by an 8-bit register index.
package motor_tuning_pkg;

	// ---------------------------------------------------------------
	// Register indices
	// ---------------------------------------------------------------
	localparam logic [7:0] MOTOR_HALT_REGISTER_ADDR = 8'h60;
	localparam logic [7:0] TACH_RES_WORD_ADDR       = 8'h90;
	localparam logic [7:0] BEMF_ADV_WORD_ADDR       = 8'h91;
	localparam logic [7:0] UNUSED_LO_FIRST          = 8'h37;
	localparam logic [7:0] UNUSED_LO_LAST           = 8'h5f;
	localparam logic [7:0] UNUSED_HI_FIRST          = 8'h61;
	localparam logic [7:0] UNUSED_HI_LAST           = 8'h8f;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int MOTOR_HALT_BIT_POS    = 15;
	localparam int DITHER_SELECT_LSB     = 14;
	localparam int TACH_OL_SELECT_LSB    = 12;
	localparam int TACH_DIVIDER_LSB      = 8;
	localparam int CYCLE_ADJUST_POS      = 7;
	localparam int RES_SHIFT_LSB         = 4;
	localparam int RES_MANTISSA_LSB      = 0;
	localparam int BEMF_RSVD_POS         = 15;
	localparam int BEMF_SHIFT_LSB        = 12;
	localparam int BEMF_MANTISSA_LSB     = 8;
	localparam int ADV_MODE_POS          = 7;
	localparam int ADV_SHIFT_LSB         = 4;
	localparam int ADV_MANTISSA_LSB      = 0;

	// Writable bits of the bemf/advance word; bit 15 stays zero
	localparam logic [15:0] BEMF_ADV_WRITE_MASK = 16'h7fff;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] TACH_RES_WORD_RESET = 16'h0000;
	localparam logic [15:0] BEMF_ADV_WORD_RESET = 16'h0000;
	localparam logic        MOTOR_HALT_RESET    = 1'b0;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		DITHER_NONE = 2'h0,
		DITHER_5PCT = 2'h1,
		DITHER_10PCT = 2'h2,
		DITHER_15PCT = 2'h3
	} dither_select_t;

	typedef enum logic [1:0] {
		TACH_OPEN_AND_CLOSED = 2'h0,
		TACH_CLOSED_ONLY     = 2'h1,
		TACH_CLOSED_FIRST_OL = 2'h2,
		TACH_RESERVED        = 2'h3
	} tach_openloop_select_t;

	// Mantissa 4 bits shifted by up to 7 gives 11 bits
	localparam int PARAM_W = 11;
	// Ratio of back-EMF to supply in Q8 (256 = 1.0)
	localparam int RATIO_FRAC_BITS = 8;

endpackage

// ===== rtl/tach_cfg_if.sv
// Interface carrying tach configuration from the register bank to the tach divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tach_cfg_if;
	import motor_tuning_pkg::*;
	tach_openloop_select_t openloop_select;
	logic [3:0]            divider;
	modport cfg  (output openloop_select, output divider);
	modport tach (input openloop_select, input divider);
endinterface
`default_nettype wire

// ===== rtl/tach_divider.sv
// Tach output generator: divides electrical-revolution events and gates them by loop state.
// Assumes elec_pulse is a one-cycle event synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module tach_divider (
	input  wire logic clk,
	input  wire logic rst_n,
	tach_cfg_if.tach  cfg,
	input  wire logic elec_pulse,
	input  wire logic closed_loop,
	input  wire logic first_open_loop,
	output var  logic tach_output
);
	import motor_tuning_pkg::*;

	typedef struct packed {
		logic [3:0] count;
		logic       pulse;
	} tach_state_t;

	tach_state_t state_reg;
	tach_state_t state_next;
	logic        gate_open;

	// -----------------------------------------------------------
	// Loop-state gating and division
	// -----------------------------------------------------------
	always_comb begin
		case (cfg.openloop_select)
			TACH_OPEN_AND_CLOSED: gate_open = 1'b1;
			TACH_CLOSED_ONLY:     gate_open = closed_loop;
			TACH_CLOSED_FIRST_OL: gate_open = closed_loop | first_open_loop;
			default:              gate_open = 1'b0;
		endcase
		state_next = state_reg;
		state_next.pulse = 1'b0;
		// One output pulse per (n + 1) electrical events
		if (elec_pulse) begin
			if (state_reg.count >= cfg.divider) begin
				state_next.count = 4'h0;
				state_next.pulse = gate_open;
			end else begin
				state_next.count = state_reg.count + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tach_output = state_reg.pulse;
endmodule
`default_nettype wire

// ===== testbench/motor_tuning_asserts.sv
// Port-level checks for the motor tuning register bank.
// Assumes one clk domain with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module motor_tuning_asserts (
	input wire logic                             clk,
	input wire logic                             rst_n,
	input wire logic [7:0]                       reg_addr,
	input wire logic [15:0]                      reg_wdata,
	input wire logic                             reg_wr_en,
	input wire logic                             reg_rd_en,
	input wire logic [15:0]                      reg_rdata,
	input wire logic                             reg_rd_valid,
	input wire logic                             motor_halt_bit,
	input wire motor_tuning_pkg::dither_select_t dither_select,
	input wire logic [10:0]                      resistance_param
);
	import motor_tuning_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_valid_a: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read not answered");
	valid_cause_a: assert property (reg_rd_valid |-> $past(reg_rd_en))
		else $error("valid without read");
	unused_lo_a: assert property (
		reg_rd_en && reg_addr inside {[8'h37:8'h5f]} |=> reg_rdata == 16'h0000)
		else $error("unused low reads nonzero");
	unused_hi_a: assert property (
		reg_rd_en && reg_addr inside {[8'h61:8'h8f]} |=> reg_rdata == 16'h0000)
		else $error("unused high reads nonzero");
	halt_read_a: assert property (
		reg_rd_en && reg_addr == 8'h60 |=> reg_rdata == 16'h0000)
		else $error("halt register not reading zero");
	halt_write_a: assert property (
		reg_wr_en && reg_addr == 8'h60 |=> motor_halt_bit == $past(reg_wdata[15]))
		else $error("halt bit not taken");
	// A one-edge reset also clears the bit, so that counts as a cause
	halt_hold_a: assert property (
		!$stable(motor_halt_bit) |-> $past(reg_wr_en && reg_addr == 8'h60) || $past(!rst_n))
		else $error("halt bit moved by itself");
	dither_sel_a: assert property (
		reg_wr_en && reg_addr == 8'h90 |=> dither_select == $past(reg_wdata[15:14]))
		else $error("dither select wrong");
	res_param_a: assert property (
		reg_wr_en && reg_addr == 8'h90 |=> ##1
		resistance_param == (11'($past(reg_wdata[3:0], 2)) << $past(reg_wdata[6:4], 2)))
		else $error("resistance parameter wrong");
	rsvd_read_a: assert property (
		reg_rd_en && reg_addr == 8'h91 |=> !reg_rdata[15])
		else $error("reserved bit reads one");
endmodule
bind motor_tuning_register_bank motor_tuning_asserts chk (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
	.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .motor_halt_bit(motor_halt_bit),
	.dither_select(dither_select), .resistance_param(resistance_param));
`default_nettype wire

// ===== testbench/host_model.sv
// Host controller model on the decoded register port.
// Assumes the bank takes strobes at the rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic        clk,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rd_valid,
	output var  logic [7:0]  reg_addr,
	output var  logic [15:0] reg_wdata,
	output var  logic        reg_wr_en,
	output var  logic        reg_rd_en
);
	initial {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = 26'h0;
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= (a == 8'h91) ? {1'b0, d[14:0]} : d;
		reg_wr_en <= 1'b1;
		@(posedge clk);
		reg_wr_en <= 1'b0;
		// Stale data would hide a late sample
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		#1;
		v = reg_rd_valid;
		d = reg_rdata;
	endtask
	// Keeps the upper four bits, so low bits of long codes are lost
	function automatic logic [6:0] res_code(input logic [10:0] c);
		logic [2:0] s;
		s = 3'h0;
		while (c > 11'h00f) begin
			c = c >> 1;
			s = s + 3'h1;
		end
		return {s, c[3:0]};
	endfunction
endmodule
`default_nettype wire

// ===== testbench/motor_tuning_register_bank_tb_top.sv
// Self-checking bench for the motor tuning register bank.
// Assumes host_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module motor_tuning_register_bank_tb_top;
	import motor_tuning_pkg::*;
	logic           clk = 1'b0;
	logic           rst_n = 1'b0;
	logic [7:0]     addr;
	logic [7:0]     ptr = 8'h90;
	logic [15:0]    wdata, rdata, nvq, d;
	logic [15:0]    nvd = 16'h0000;
	logic           wr_en, rd_en, rvalid, halt, cyc, amode, tach, v;
	logic           nvl = 1'b0, ep = 1'b0, cl = 1'b0, fol = 1'b0;
	logic [8:0]     ratio = 9'h100;
	dither_select_t dith;
	logic [10:0]    rp, kp, ap;
	int             error_cnt = 0;
	int             compares = 0;
	motor_tuning_register_bank dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_rdata(rdata), .reg_rd_valid(rvalid),
		.single_access_pointer(ptr), .nv_load_en(nvl), .nv_load_data(nvd), .nv_read_data(nvq),
		.elec_pulse(ep), .closed_loop(cl), .first_open_loop(fol), .bemf_ratio_q8(ratio),
		.motor_halt_bit(halt), .dither_select(dith), .cycle_adjust_select(cyc),
		.resistance_param(rp), .bemf_const_param(kp), .advance_mode_select(amode),
		.advance_time_param(ap), .tach_output(tach));
	host_model h (.clk(clk), .reg_rdata(rdata), .reg_rd_valid(rvalid), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr_en(wr_en), .reg_rd_en(rd_en));
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Params trail a write by two edges
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic t_reset();
		logic [7:0] m [3] = '{8'h60, 8'h90, 8'h91};
		foreach (m[i]) begin
			h.rd(m[i], d, v);
			chk(v, 1'b1);
			chk(d, 16'h0000);
		end
		chk({halt, dith, rp}, 16'h0000);
		$display("t_reset done");
	endtask
	task automatic t_tach_res();
		logic [6:0] rc;
		rc = h.res_code(11'h02d);
		chk(rc, 7'h2b);
		for (int i = 0; i < 4; i++) begin
			h.wr(8'h90, {i[1:0], 6'h00, i[0], rc});
			settle();
			chk(dith, i[1:0]);
			chk(cyc, i[0]);
			chk(rp, 11'h02c);
			chk(nvq, {i[1:0], 6'h00, i[0], rc});
			h.rd(8'h90, d, v);
			chk(d, {i[1:0], 6'h00, i[0], rc});
		end
		@(posedge clk);
		nvl <= 1'b1;
		nvd <= 16'h0125;
		@(posedge clk);
		nvl <= 1'b0;
		settle();
		chk(rp, 11'h014);
		$display("t_tach_res done");
	endtask
	task automatic t_bemf();
		h.wr(8'h91, 16'hff35);
		settle();
		chk(kp, 11'h780);
		chk({amode, ap}, 12'h028);
		h.rd(8'h91, d, v);
		chk(d, 16'h7f35);
		@(posedge clk);
		ratio <= 9'h080;
		h.wr(8'h91, 16'h7fb5);
		settle();
		chk({amode, ap}, 12'h814);
		// Ratio near two on the largest base must clip, not wrap
		@(posedge clk);
		ratio <= 9'h1ff;
		h.wr(8'h91, 16'h00ff);
		settle();
		chk(kp, 11'h000);
		chk({amode, ap}, 12'hfff);
		// The load path is not bound by host etiquette, so it can carry bit 15
		@(posedge clk);
		ptr <= 8'h91;
		nvl <= 1'b1;
		nvd <= 16'hc3a4;
		@(posedge clk);
		nvl <= 1'b0;
		settle();
		chk(nvq, 16'h43a4);
		chk(kp, 11'h030);
		chk({amode, ap}, 12'h81f);
		h.rd(8'h91, d, v);
		chk(d, 16'h43a4);
		$display("t_bemf done");
	endtask
	task automatic t_halt_unused();
		logic [7:0] u [4] = '{8'h37, 8'h5f, 8'h61, 8'h8f};
		h.wr(8'h60, 16'h8000);
		settle();
		chk(halt, 1'b1);
		h.rd(8'h60, d, v);
		chk(d, 16'h0000);
		h.wr(8'h60, 16'h0000);
		settle();
		chk(halt, 1'b0);
		foreach (u[i]) begin
			h.wr(u[i], 16'hffff);
			h.rd(u[i], d, v);
			chk(v, 1'b1);
			chk(d, 16'h0000);
		end
		h.rd(8'h90, d, v);
		chk({halt, d[14:0]}, 16'h0125);
		$display("t_halt_unused done");
	endtask
	task automatic t_tach();
		logic [15:0] cfg [6] = '{16'h0100, 16'h1100, 16'h1100, 16'h2300, 16'h3100, 16'h0000};
		logic [1:0] lp [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h0};
		logic [15:0] ex [6] = '{16'h2, 16'h0, 16'h2, 16'h1, 16'h0, 16'h4};
		logic [15:0] n;
		for (int k = 0; k < 6; k++) begin
			h.wr(8'h90, cfg[k]);
			{fol, cl} <= lp[k];
			n = 16'h0;
			repeat (4) begin
				@(posedge clk);
				ep <= 1'b1;
				@(posedge clk);
				ep <= 1'b0;
				#1;
				n = n + (tach === 1'b1);
			end
			chk(n, ex[k]);
		end
		$display("t_tach done");
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_tach_res();
		t_bemf();
		t_halt_unused();
		t_tach();
		test_done();
	end
endmodule
`default_nettype wire
